// ---- measurement_cycle_sequencer.sv ----
// Functional notes
// RULE_01: Timebase starts cycles at selected interval
// RULE_02: Six channels read in fixed order
// RULE_03: Absent sensors give 0 and 1023
// RULE_04: Reference channel gives fixed value
// RULE_05: Rotor counts each half revolution
// RULE_06: Power reset restarts interval timebase
// RULE_07: Position 0 starts only on manual; the code also starts on terminal trigger or software start
// RULE_08: Operator sets interval, then presses start
// RULE_09: Each word sent live while stored
// RULE_10: Terminal trigger in, coded data out
// RULE_11: Temperature range selects one of three
// RULE_12: Every result is one 10-bit word
// RULE_13: After last word, return idle
// RULE_14: Triggers during a cycle are ignored; the code still restarts the interval count on them
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module measurement_cycle_sequencer
  #(
  parameter int TICK_CNT = mcs_pkg::TICK_CYCLES,
  parameter int STEP_TICKS = mcs_pkg::TICKS_PER_STEP
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        MANUAL_START,
  input  wire logic        TERM_TRIGGER,
  input  wire logic        ROTOR_PULSE,
  input  wire logic [9:0]  TEMP_RAW,
  input  wire logic [9:0]  COND_RAW,
  input  wire logic [9:0]  PRES_RAW,
  input  wire logic [9:0]  DIR_RAW,
  output logic [9:0]       STORE_DATA,
  output logic             STORE_VALID,
  input  wire logic        STORE_READY,
  output logic [9:0]       LIVE_DATA,
  output logic             LIVE_VALID,
  output logic [2:0]       LIVE_CHANNEL,
  output logic             BUSY
);
  import mcs_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum {S_IDLE, S_LOAD, S_PUSH, S_DRAIN} seq_t;
  seq_t             st_reg, st_next;          // Sequencer state
  logic [2:0]       ch_reg, ch_next;          // Channel index
  logic [WORD_W-1:0] word_reg, word_next;     // Current word
  logic [31:0]      tick_reg, tick_next;      // Tick divider
  logic [31:0]      ivl_reg, ivl_next;        // Interval tick counter
  logic [15:0]      rotor_reg, rotor_next;    // Half-revolution count
  logic [15:0]      ncyc_reg, ncyc_next;      // Completed cycles
  logic [8:0]       ctrl_reg, ctrl_next;      // Control register
  logic [9:0]       ref_reg, ref_next;        // Reference word
  logic [31:0]      prdata_next;
  logic             pready_next, pslverr_next;
  logic [9:0]       lv_data_next;
  logic             lv_valid_next;
  logic [2:0]       lv_ch_next;
  logic [2:0]       man_s, trg_s, rot_s;      // Three-stage synchronisers
  logic             man_q, trg_q, rot_q;      // Filtered levels
  logic             man_rise, trg_rise, rot_rise;
  logic             tick_en, due, start_req, sw_start;
  logic             apb_wr, apb_rd;
  logic             f_in_valid, f_in_ready;
  logic [9:0]       f_out_data, st_data_next;   // FIFO head, store word
  logic             f_out_valid, st_free, st_valid_next;

  // Sensor word select by channel index and range
  function automatic logic [9:0] chan_word(input logic [2:0] ch,
                                           input logic [8:0] ctl,
                                           input logic [9:0] refv,
                                           input logic [15:0] rot);
    logic [9:0] t;
    t = TEMP_RAW;
    // RULE_11: wide range halves the word, high range zeroes words up to 10'h1FF
    case (trange_t'(ctl[CTRL_TRNG_LSB +: 2]))
      TR_LOW:  t = TEMP_RAW;
      TR_WIDE: t = {1'b0, TEMP_RAW[9:1]};
      TR_HIGH: t = (TEMP_RAW > 10'h1FF) ? TEMP_RAW : 10'h000;
      default: t = TEMP_RAW;
    endcase
    case (ch)
      // RULE_04: fixed reference
      3'h0:    chan_word = refv;
      3'h1:    chan_word = t;
      // RULE_03: absent sensor constants
      3'h2:    chan_word = ctl[CTRL_CPRES_BIT] ? COND_RAW : COND_ABSENT;
      3'h3:    chan_word = ctl[CTRL_PPRES_BIT] ? PRES_RAW : PRES_ABSENT;
      3'h4:    chan_word = DIR_RAW;
      // RULE_12: ten-bit rotor word
      default: chan_word = rot[9:0];
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers, change counts when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      man_s <= '0;
      trg_s <= '0;
      rot_s <= '0;
      man_q <= 1'b0;
      trg_q <= 1'b0;
      rot_q <= 1'b0;
    end else begin
      man_s <= {man_s[1:0], MANUAL_START};
      trg_s <= {trg_s[1:0], TERM_TRIGGER};
      rot_s <= {rot_s[1:0], ROTOR_PULSE};
      if (man_s[1] == man_s[2]) man_q <= man_s[2];
      if (trg_s[1] == trg_s[2]) trg_q <= trg_s[2];
      if (rot_s[1] == rot_s[2]) rot_q <= rot_s[2];
    end
  end

  // Edge detection on filtered levels only
  always_comb begin
    man_rise = (man_s[2] == man_s[1]) && man_s[2] && !man_q;
    trg_rise = (trg_s[2] == trg_s[1]) && trg_s[2] && !trg_q;
    rot_rise = (rot_s[2] == rot_s[1]) && rot_s[2] && !rot_q;
  end

  // ---------------------------------------------------------------
  // APB decode and next values
  // ---------------------------------------------------------------
  always_comb begin
    apb_wr       = PSEL && PENABLE && PWRITE;
    apb_rd       = PSEL && !PENABLE && !PWRITE;
    ctrl_next    = ctrl_reg;
    ref_next     = ref_reg;
    sw_start     = 1'b0;
    pready_next  = PSEL && !PENABLE;  // One wait-free access cycle
    pslverr_next = 1'b0;
    prdata_next  = PRDATA;
    if (apb_wr) begin
      case (PADDR)
        CTRL_OFS: begin
          ctrl_next = {1'b0, PWDATA[7:0]};
          sw_start  = PWDATA[CTRL_START_BIT];
        end
        REFVAL_OFS: ref_next = PWDATA[9:0];
        STATUS_OFS, ROTOR_OFS, CYCLES_OFS: ;
        default: ;
      endcase
    end
    if (PSEL && !PENABLE) begin
      pslverr_next = !(PADDR inside {CTRL_OFS, STATUS_OFS, REFVAL_OFS,
                                     ROTOR_OFS, CYCLES_OFS});
    end
    if (apb_rd) begin
      case (PADDR)
        CTRL_OFS:   prdata_next = {23'h0, ctrl_reg};
        STATUS_OFS: prdata_next = {25'h0, f_out_valid, !f_in_ready,
                                   ch_reg, BUSY, 1'b0};
        REFVAL_OFS: prdata_next = {22'h0, ref_reg};
        ROTOR_OFS:  prdata_next = {16'h0, rotor_reg};
        CYCLES_OFS: prdata_next = {16'h0, ncyc_reg};
        default:    prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Timebase next values
  // ---------------------------------------------------------------
  always_comb begin
    tick_en   = (tick_reg == 32'(TICK_CNT - 1));
    tick_next = tick_en ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
    // RULE_01: selector scales interval
    due       = (ctrl_reg[SEL_W-1:0] != SEL_MANUAL) && tick_en &&
                (ivl_reg + 32'h0000_0001 >=
                 32'(ctrl_reg[SEL_W-1:0]) * 32'(STEP_TICKS));
    // RULE_07: manual position starts on press, terminal trigger or software start
    // RULE_10: terminal trigger starts cycle
    start_req = due || man_rise || trg_rise || sw_start;
    ivl_next  = ivl_reg;
    if (tick_en) ivl_next = ivl_reg + 32'h0000_0001;
    // RULE_08: manual start restarts interval
    if (due || man_rise || trg_rise || sw_start) ivl_next = 32'h0000_0000;
    // RULE_05: count half revolutions
    rotor_next = rotor_reg + (rot_rise ? 16'h0001 : 16'h0000);
  end

  // ---------------------------------------------------------------
  // Sequencer next values
  // ---------------------------------------------------------------
  always_comb begin
    st_next       = st_reg;
    ch_next       = ch_reg;
    word_next     = word_reg;
    ncyc_next     = ncyc_reg;
    f_in_valid    = 1'b0;
    lv_valid_next = 1'b0;
    lv_data_next  = LIVE_DATA;
    lv_ch_next    = LIVE_CHANNEL;
    // Store register reloads only when empty or taken, so no word is lost
    st_free       = !STORE_VALID || STORE_READY;
    st_data_next  = (f_out_valid && st_free) ? f_out_data : STORE_DATA;
    st_valid_next = f_out_valid || (STORE_VALID && !STORE_READY);
    case (st_reg)
      // RULE_14: cycle starts only taken here; triggers still restart the interval count in any state
      S_IDLE: if (start_req) begin
        ch_next = 3'h0;
        st_next = S_LOAD;
      end
      S_LOAD: begin
        word_next = chan_word(ch_reg, ctrl_reg, ref_reg, rotor_reg);
        st_next   = S_PUSH;
      end
      S_PUSH: begin
        f_in_valid = 1'b1;
        if (f_in_ready) begin
          // RULE_09: live copy with store
          lv_valid_next = 1'b1;
          lv_data_next  = word_reg;
          lv_ch_next    = ch_reg;
          // RULE_02: next channel in order
          if (ch_reg == 3'(NUM_CH - 1)) begin
            st_next = S_DRAIN;
          end else begin
            ch_next = ch_reg + 3'h1;
            st_next = S_LOAD;
          end
        end
      end
      // RULE_13: back to idle after store
      S_DRAIN: if (!f_out_valid && st_free) begin
        ncyc_next = ncyc_reg + 16'h0001;
        st_next   = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      st_reg       <= S_IDLE;
      ch_reg       <= 3'h0;
      word_reg     <= '0;
      // RULE_06: reset clears timebase
      tick_reg     <= '0;
      ivl_reg      <= '0;
      rotor_reg    <= '0;
      ncyc_reg     <= '0;
      ctrl_reg     <= '0;
      ref_reg      <= REF_DEFAULT;
      PRDATA       <= '0;
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      LIVE_DATA    <= '0;
      LIVE_VALID   <= 1'b0;
      LIVE_CHANNEL <= 3'h0;
      BUSY         <= 1'b0;
    end else begin
      st_reg       <= st_next;
      ch_reg       <= ch_next;
      word_reg     <= word_next;
      tick_reg     <= tick_next;
      ivl_reg      <= ivl_next;
      rotor_reg    <= rotor_next;
      ncyc_reg     <= ncyc_next;
      ctrl_reg     <= ctrl_next;
      ref_reg      <= ref_next;
      PRDATA       <= prdata_next;
      PREADY       <= pready_next;
      PSLVERR      <= pslverr_next;
      LIVE_DATA    <= lv_data_next;
      LIVE_VALID   <= lv_valid_next;
      LIVE_CHANNEL <= lv_ch_next;
      BUSY         <= (st_next != S_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Store path buffer; store stalls apply back-pressure to sequencer
  // ---------------------------------------------------------------
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst       (RESET),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (word_reg),
    .out_valid (f_out_valid),
    .out_ready (st_free),
    .out_data  (f_out_data)
  );

  // Registered store outputs; word held while the store stalls
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      STORE_DATA  <= '0;
      STORE_VALID <= 1'b0;
    end else begin
      STORE_DATA  <= st_data_next;
      STORE_VALID <= st_valid_next;
    end
  end
endmodule
`default_nettype wire

// ---- mcs_pkg.sv ----
package mcs_pkg;
  // ---------------------------------------------------------------
  // Word and channel layout
  // ---------------------------------------------------------------
  localparam int          WORD_W       = 10;        // One channel word
  localparam int          NUM_CH       = 6;         // Channels per cycle
  localparam logic [9:0]  COND_ABSENT  = 10'h000;   // Conductivity absent
  localparam logic [9:0]  PRES_ABSENT  = 10'h3FF;   // Pressure absent
  localparam logic [9:0]  REF_DEFAULT  = 10'h2AA;   // Arbitrary value
  localparam int          FIFO_DEPTH   = 32;        // Store path buffer

  // ---------------------------------------------------------------
  // Timebase and interval selector
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;       // SYS_CLK rate
  localparam int TICK_US       = 1000;              // Timebase tick, us
  localparam int TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int TICKS_PER_STEP = 60_000;           // Ticks per selector step
  localparam int SEL_W         = 4;                 // Interval selector width
  localparam logic [3:0] SEL_MANUAL = 4'h0;         // Manual-start position

  // ---------------------------------------------------------------
  // APB register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;       // Control
  localparam logic [7:0] STATUS_OFS  = 8'h04;       // Status
  localparam logic [7:0] REFVAL_OFS  = 8'h08;       // Reference word
  localparam logic [7:0] ROTOR_OFS   = 8'h0C;       // Rotor count
  localparam logic [7:0] CYCLES_OFS  = 8'h10;       // Completed cycles
  localparam int CTRL_SEL_LSB   = 0;                // Interval selector
  localparam int CTRL_TRNG_LSB  = 4;                // Temperature range
  localparam int CTRL_CPRES_BIT = 6;                // Conductivity present
  localparam int CTRL_PPRES_BIT = 7;                // Pressure present
  localparam int CTRL_START_BIT = 8;                // Software start

  // Temperature range selector codes
  typedef enum logic [1:0] {TR_LOW, TR_WIDE, TR_HIGH} trange_t;
endpackage

// ---- word_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage flip-flops
  logic [AW-1:0]    wr_reg, rd_reg;    // Pointers
  logic [AW-1:0]    wr_next, rd_next;  // Next pointers
  logic [AW:0]      cnt_reg, cnt_next; // Fill level
  logic             push, pop;

  // ---------------------------------------------------------------
  // Handshake and level
  // ---------------------------------------------------------------
  always_comb begin
    in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    out_valid = (cnt_reg != '0);
    out_data  = mem_reg[rd_reg];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    wr_next   = push ? wr_reg + AW'(1) : wr_reg;
    rd_next   = pop ? rd_reg + AW'(1) : rd_reg;
  end

  // Pointer registers; wrap relies on power-of-two depth
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // Data storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_reg[wr_reg] <= in_data;
  end
endmodule
`default_nettype wire

// ---- mcs_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Sequencer port checker
// ------------------------------------------
module mcs_checker (
  input wire logic        SYS_CLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [9:0]  STORE_DATA,
  input wire logic        STORE_VALID,
  input wire logic        STORE_READY,
  input wire logic        LIVE_VALID,
  input wire logic [2:0]  LIVE_CHANNEL,
  input wire logic        BUSY
);
  logic [2:0] ch_reg;   // Live words seen this cycle
  logic [2:0] ch_next;  // Next count
  // Count restarts whenever the sequencer is idle
  always_comb begin
    ch_next = BUSY ? ch_reg + {2'h0, LIVE_VALID} : 3'h0;
  end
  // Register only
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ch_reg <= 3'h0;
    end else begin
      ch_reg <= ch_next;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence answer_s;
    PREADY ##1 !PREADY;
  endsequence
  apb_ready_a: assert property (setup_s |=> answer_s)
    else $error("ready not one cycle after setup");
  unmapped_read_a: assert property (setup_s ##0 (!PWRITE && PADDR > 8'h10) |=>
    PSLVERR && PRDATA == 32'h0) else $error("unmapped read not refused");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error outside access answer");
  live_order_a: assert property (LIVE_VALID |-> LIVE_CHANNEL == ch_reg)
    else $error("channel out of order");
  live_gap_a: assert property (LIVE_VALID |-> BUSY ##1 !LIVE_VALID)
    else $error("live pulse not single");
  store_hold_a: assert property (STORE_VALID && !STORE_READY |=>
    STORE_VALID && $stable(STORE_DATA)) else $error("store word dropped");
  cycle_end_a: assert property ($fell(BUSY) |-> ch_reg == 3'h6)
    else $error("cycle ended without six words");
  first_word_a: assert property ($rose(BUSY) |-> ##[0:8]
    (LIVE_VALID && LIVE_CHANNEL == 3'h0)) else $error("first word late");
endmodule
bind measurement_cycle_sequencer mcs_checker i_mcs_checker (
  .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .STORE_DATA(STORE_DATA), .STORE_VALID(STORE_VALID),
  .STORE_READY(STORE_READY), .LIVE_VALID(LIVE_VALID),
  .LIVE_CHANNEL(LIVE_CHANNEL), .BUSY(BUSY));
`default_nettype wire

// ---- store_sink.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Removable store model
// ------------------------------------------
module store_sink (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [9:0] data,
  input wire logic       valid,
  input wire logic       stall,
  input wire logic       slow,
  output logic           ready
);
  logic       phase_reg;      // Ready phase
  logic       phase_next;     // Next phase
  logic [9:0] words [0:63];   // Words taken
  int         count = 0;      // Words taken so far
  // Slow store accepts only every other cycle
  always_comb begin
    phase_next = slow ? !phase_reg : 1'b1;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end
  assign ready = !stall && phase_reg;
  // Log each word on a completed handshake
  always @(posedge clk) begin
    if (valid && ready && !rst) begin
      words[count[5:0]] <= data;
      count <= count + 1;
    end
  end
endmodule
`default_nettype wire

// ---- measurement_cycle_sequencer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Sequencer bench
// ------------------------------------------
module measurement_cycle_sequencer_tb;
  import mcs_pkg::*;
  logic        SYS_CLK, RESET, PSEL, PENABLE, PWRITE, MANUAL_START, TERM_TRIGGER;
  logic        ROTOR_PULSE, STORE_READY, PREADY, PSLVERR, LIVE_VALID, STORE_VALID;
  logic        BUSY, stall, slow, err, busy_q;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [9:0]  TEMP_RAW, COND_RAW, PRES_RAW, DIR_RAW, STORE_DATA, LIVE_DATA;
  logic [2:0]  LIVE_CHANNEL;
  logic [9:0]  live_d [0:7];  // Live words of one cycle
  logic [2:0]  live_c [0:7];  // Their channel numbers
  int          err_total, n_tests, live_n, rises, base;
  // Short counts keep the timebase runs brief
  measurement_cycle_sequencer #(.TICK_CNT(4), .STEP_TICKS(2)) i_measurement_cycle_sequencer (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .MANUAL_START(MANUAL_START), .TERM_TRIGGER(TERM_TRIGGER), .ROTOR_PULSE(ROTOR_PULSE),
    .TEMP_RAW(TEMP_RAW), .COND_RAW(COND_RAW), .PRES_RAW(PRES_RAW), .DIR_RAW(DIR_RAW),
    .STORE_DATA(STORE_DATA), .STORE_VALID(STORE_VALID), .STORE_READY(STORE_READY),
    .LIVE_DATA(LIVE_DATA), .LIVE_VALID(LIVE_VALID), .LIVE_CHANNEL(LIVE_CHANNEL), .BUSY(BUSY));
  store_sink sink (.clk(SYS_CLK), .rst(RESET), .data(STORE_DATA), .valid(STORE_VALID),
    .stall(stall), .slow(slow), .ready(STORE_READY));
  always #5 SYS_CLK = ~SYS_CLK;
  // Capture live words and count cycle starts
  always @(posedge SYS_CLK) begin
    if (LIVE_VALID === 1'b1) begin
      live_d[live_n[2:0]] = LIVE_DATA;
      live_c[live_n[2:0]] = LIVE_CHANNEL;
      live_n++;
    end
    if (BUSY === 1'b1 && busy_q !== 1'b1) rises++;
    busy_q = BUSY;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    // No limit of its own; ends when ready is seen, else only the watchdog ends it
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Idle edge keeps the next setup apart from this release
    @(posedge SYS_CLK);
  endtask
  // Pin pulse long enough for the input synchroniser
  task pulse(input int pin);
    case (pin)
      0: MANUAL_START <= 1'b1;
      1: TERM_TRIGGER <= 1'b1;
      default: ROTOR_PULSE <= 1'b1;
    endcase
    repeat (4) @(posedge SYS_CLK);
    {MANUAL_START, TERM_TRIGGER, ROTOR_PULSE} <= 3'b000;
    repeat (4) @(posedge SYS_CLK);
  endtask
  task wait_idle;
    int n;
    n = 0;
    while (BUSY !== 1'b0 && n < 2000) begin
      @(posedge SYS_CLK);
      n++;
    end
    chk({31'h0, BUSY}, 32'h0);
    repeat (2) @(posedge SYS_CLK);
  endtask
  // Judge the six words of the last cycle, store and live alike
  task cyc(input logic [9:0] c, input logic [9:0] p, input logic [9:0] r);
    logic [9:0] e [0:5];
    // Low temperature range passes the raw word through
    e = '{REF_DEFAULT, TEMP_RAW, c, p, DIR_RAW, r};
    chk(live_n, 6);
    chk(sink.count - base, 6);
    for (int i = 0; i < 6; i++) begin
      chk(live_c[i], i);
      chk(sink.words[base + i], e[i]);
      chk(live_d[i], e[i]);
    end
  endtask
  task arm;
    live_n = 0;
    base = sink.count;
  endtask
  task s_regs;
    apb(1'b0, REFVAL_OFS, 32'h0);
    chk(rd, {22'h0, REF_DEFAULT});
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask
  // Absent sensors, manual start, store stalled then slow
  task s_manual;
    TEMP_RAW <= 10'h155;
    COND_RAW <= 10'h123;
    PRES_RAW <= 10'h234;
    DIR_RAW  <= 10'h0F0;
    stall <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (5) pulse(2);
    arm();
    pulse(0);
    repeat (30) @(posedge SYS_CLK);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk({30'h0, rd[6], rd[1]}, 32'h3);
    chk(live_n - (sink.count - base), 6);
    stall <= 1'b0;
    slow <= 1'b1;
    wait_idle();
    cyc(COND_ABSENT, PRES_ABSENT, 10'h5);
    apb(1'b0, CYCLES_OFS, 32'h0);
    chk(rd, 32'h1);
  endtask
  // Present sensors, terminal start, manual press ignored mid-cycle
  task s_term;
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, CTRL_OFS, 32'hC0 | (r << 4));
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'hC0 | (r << 4));
    end
    // Back to low range so the temperature word is the raw one
    apb(1'b1, CTRL_OFS, 32'hC0);
    stall <= 1'b1;
    arm();
    pulse(1);
    pulse(0);
    stall <= 1'b0;
    wait_idle();
    cyc(COND_RAW, PRES_RAW, 10'h5);
    repeat (40) @(posedge SYS_CLK);
    apb(1'b0, CYCLES_OFS, 32'h0);
    chk(rd, 32'h2);
  endtask
  // Interval of 15 steps is 120 clocks here
  task s_timer;
    apb(1'b1, CTRL_OFS, 32'hF);
    apb(1'b1, CTRL_OFS, 32'h10F);
    rises = 0;
    repeat (600) @(posedge SYS_CLK);
    chk(rises >= 4 && rises <= 6, 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    wait_idle();
    rises = 0;
    repeat (400) @(posedge SYS_CLK);
    chk(rises, 32'h0);
  endtask
  // Reset part-way through an interval restarts the count
  task s_reset;
    apb(1'b1, CTRL_OFS, 32'hF);
    repeat (100) @(posedge SYS_CLK);
    RESET <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    apb(1'b1, CTRL_OFS, 32'hF);
    rises = 0;
    repeat (90) @(posedge SYS_CLK);
    chk(rises, 32'h0);
    repeat (80) @(posedge SYS_CLK);
    chk(rises, 32'h1);
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial begin
    {SYS_CLK, PSEL, PENABLE, PWRITE, MANUAL_START, TERM_TRIGGER, ROTOR_PULSE} = 7'h0;
    {stall, slow, PADDR, PWDATA, busy_q} = 43'h0;
    {TEMP_RAW, COND_RAW, PRES_RAW, DIR_RAW} = 40'h0;
    {err_total, n_tests, live_n, rises} = 128'h0;
    RESET = 1'b1;
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    s_regs();
    s_manual();
    s_term();
    s_timer();
    s_reset();
    end_of_test();
  end
  // Hang guard, well beyond the roughly 1500 clocks the run needs
  initial begin
    #200_000;
    // Timeout counts as one failed check
    chk(32'h0, 32'h1);
    end_of_test();
  end
endmodule
`default_nettype wire
